// [dcsw_word_ctrl.sv]
// decoder of the drive command word and encoder of the drive condition word
//
// Overview of operation
// [RULE1] bit 02 low: DC brake and stop
// [RULE2] bit 03 low: output off, motor coasts
// [RULE3] bit 04 low: quick stop ramp down
// [RULE4] bit 05 low: freeze; only coast/brake stop
// [RULE5] bit 06 low: ramp stop; high permits start
// [RULE6] trip reset only on bit 07 rise
// [RULE7] bit 08 high: run at jog speed
// [RULE8] bit 09 selects ramp set 1 or 2
// [RULE9] bit 10 low: ignore whole command word
// [RULE10] bits 11/12 drive relays when selected
// [RULE11] bits 14:13 choose set-up when multi-set-up
// [RULE12] bit 15 reverses when serial source selected
// [RULE13] status 00 controls ready, 01 drive ready
// [RULE14] status 02 low while motor released
// [RULE15] status 03 trip, 04 error, 06 triplock
// [RULE16] status 07 warning, 13-15 limit flags
// [RULE17] status 08 speed equals reference
// [RULE18] status 09 bus control possible
// [RULE19] status 10 frequency within limits, 11 running
// [RULE20] status 12 over-temperature stop, auto restart
// [RULE21] link lost forces condition word zero
// [RULE22] speed words signed, 16384 is 100%
// [RULE23] bits 01:00 choose preset reference
`timescale 1ns/1ps
`default_nettype none
`include "dcsw_defs.svh"
module dcsw_word_ctrl
    import dcsw_pkg::*;
#(
    parameter int WORD_W = 16
)
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // received telegram words
    input  wire logic              cmd_strobe_i,      // new command word present
    input  wire logic [WORD_W-1:0] drive_command_word_i,
    input  wire logic [WORD_W-1:0] speed_ref_i,       // signed relative reference
    // configuration selections
    input  wire logic              relay1_sel_cmd_i,  // relay 1 follows bit 11
    input  wire logic              relay2_sel_cmd_i,  // relay 2 follows bit 12
    input  wire logic              multi_setup_i,     // multi set-up operation
    input  wire logic              reverse_sel_bus_i, // reversing source includes bus
    // drive state inputs
    input  wire logic              link_ok_i,
    input  wire logic              ctrl_ready_i,
    input  wire logic              drive_ready_i,
    input  wire logic              trip_i,
    input  wire logic              error_i,
    input  wire logic              triplock_i,
    input  wire logic              warning_i,
    input  wire logic              local_mode_i,      // local stop or local site
    input  wire logic              speed_lim_hit_i,
    input  wire logic              overtemp_stop_i,
    input  wire logic              volt_exc_i,
    input  wire logic              torq_exc_i,
    input  wire logic              timer_exc_i,
    input  wire logic              start_sig_i,       // start from other sources
    input  wire logic [WORD_W-1:0] actual_output_frequency_value_i,
    // motor control outputs
    output var  logic              dc_brake_o,
    output var  logic              coast_o,
    output var  logic              quick_stop_o,
    output var  logic              freeze_o,
    output var  logic              run_o,
    output var  logic              jog_o,
    output var  logic              ramp2_o,
    output var  logic              reverse_o,
    output var  logic [1:0]        preset_sel_o,
    output var  logic [1:0]        setup_sel_o,
    output var  logic              relay1_o,
    output var  logic              relay2_o,
    output var  logic              trip_reset_o,      // one-cycle pulse
    output var  logic [WORD_W-1:0] speed_ref_o,
    // returned words
    output var  logic [WORD_W-1:0] drive_condition_word_o,
    output var  logic [WORD_W-1:0] actual_output_frequency_value_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WORD_W-1:0] cmd;     // last accepted command word
        logic [WORD_W-1:0] spd_ref; // last accepted speed reference
        logic [WORD_W-1:0] sts;     // condition word
        logic [WORD_W-1:0] freq_back; // returned frequency
        logic              brake;
        logic              coast;
        logic              qstop;
        logic              freeze;
        logic              run;
        logic              relay1;
        logic              relay2;
        logic              reverse;
        logic [1:0]        setup;
    } dcsw_st_t;

    dcsw_st_t   st_q;
    dcsw_st_t   st_d;
    dcsw_stop_t stop_sel;   // winning stop action
    logic       accept;     // command word is valid and bus may control
    logic       rst_pulse;  // reset edge from detector
    logic [WORD_W-1:0] c;   // alias for incoming command

    assign c      = drive_command_word_i;
    // bus control refused in local mode; data-valid gates the word
    assign accept = cmd_strobe_i & c[`DCSW_CMD_VALID] & ~local_mode_i; // [RULE9] [RULE18]

    // ------------------------------------------------------------------
    // reset edge detection
    // ------------------------------------------------------------------
    dcsw_edge_det u_rst_edge
    (
        .clk_sys_i (clk_sys_i),
        .reset_i   (reset_i),
        .level_i   (c[`DCSW_CMD_RESET]),
        .sample_i  (accept),
        .rise_o    (rst_pulse)          // [RULE6]
    );

    // ------------------------------------------------------------------
    // stop priority from the held command word
    // ------------------------------------------------------------------
    always_comb
    begin
        stop_sel = DCSW_STOP_NONE;
        if (!st_q.cmd[`DCSW_CMD_NCOAST])
            stop_sel = DCSW_STOP_COAST;                  // [RULE2]
        else if (!st_q.cmd[`DCSW_CMD_RAMP_NBRAKE])
            stop_sel = DCSW_STOP_BRAKE;                  // [RULE1]
        else if (!st_q.cmd[`DCSW_CMD_NFREEZE])
            stop_sel = DCSW_STOP_NONE;                   // [RULE4]
        else if (!st_q.cmd[`DCSW_CMD_NQSTOP])
            stop_sel = DCSW_STOP_QUICK;                  // [RULE3]
        else if (!st_q.cmd[`DCSW_CMD_START])
            stop_sel = DCSW_STOP_RAMP;                   // [RULE5]
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;
        // latch only valid words; otherwise hold previous command
        if (accept)
        begin
            st_d.cmd = c;                                // [RULE9]
            st_d.spd_ref = speed_ref_i;                  // [RULE22]
        end
        // decoded actions
        st_d.coast  = (stop_sel == DCSW_STOP_COAST);
        st_d.brake  = (stop_sel == DCSW_STOP_BRAKE);
        st_d.qstop  = (stop_sel == DCSW_STOP_QUICK);
        // freeze holds unless coast or brake override it
        st_d.freeze = ~st_q.cmd[`DCSW_CMD_NFREEZE] & ~st_d.coast & ~st_d.brake; // [RULE4]
        st_d.run    = (stop_sel == DCSW_STOP_NONE) & st_q.cmd[`DCSW_CMD_START]
                      & ~trip_i & ~triplock_i;           // [RULE2] [RULE5]
        st_d.relay1 = relay1_sel_cmd_i & st_q.cmd[`DCSW_CMD_RELAY1]; // [RULE10]
        st_d.relay2 = relay2_sel_cmd_i & st_q.cmd[`DCSW_CMD_RELAY2]; // [RULE10]
        st_d.reverse = reverse_sel_bus_i & st_q.cmd[`DCSW_CMD_REVERSE]; // [RULE12]
        if (multi_setup_i)
            st_d.setup = st_q.cmd[`DCSW_CMD_SETUP_MSB:`DCSW_CMD_SETUP_LSB]; // [RULE11]
        else
            st_d.setup = 2'h0;
        // condition word, each bit but 05 from its source; bit 05 stays at its reset value
        st_d.sts = `DCSW_STS_RESET_VAL;
        st_d.sts[`DCSW_STS_CTRL_RDY]  = ctrl_ready_i & ~trip_i;     // [RULE13]
        st_d.sts[`DCSW_STS_DRV_RDY]   = drive_ready_i;              // [RULE13]
        st_d.sts[`DCSW_STS_ENABLE]    = ~st_q.coast & st_q.cmd[`DCSW_CMD_NCOAST]; // [RULE14]
        st_d.sts[`DCSW_STS_TRIP]      = trip_i;                     // [RULE15]
        st_d.sts[`DCSW_STS_ERROR]     = error_i;                    // [RULE15]
        st_d.sts[`DCSW_STS_TRIPLOCK]  = triplock_i;                 // [RULE15]
        st_d.sts[`DCSW_STS_WARNING]   = warning_i;                  // [RULE16]
        st_d.sts[`DCSW_STS_AT_SPEED]  = (actual_output_frequency_value_i == st_q.spd_ref); // [RULE17]
        st_d.sts[`DCSW_STS_BUS_CTRL]  = ~local_mode_i;              // [RULE18]
        st_d.sts[`DCSW_STS_FREQ_OK]   = ~speed_lim_hit_i;           // [RULE19]
        st_d.sts[`DCSW_STS_IN_OP]     = start_sig_i | st_q.run
                                        | (actual_output_frequency_value_i != '0); // [RULE19]
        st_d.sts[`DCSW_STS_AUTO_STOP] = overtemp_stop_i;            // [RULE20]
        st_d.sts[`DCSW_STS_VOLT_EXC]  = volt_exc_i;                 // [RULE16]
        st_d.sts[`DCSW_STS_TORQ_EXC]  = torq_exc_i;                 // [RULE16]
        st_d.sts[`DCSW_STS_TIMER_EXC] = timer_exc_i;                // [RULE16]
        st_d.freq_back = actual_output_frequency_value_i;           // [RULE22]
        // lost link blanks the whole condition word
        if (!link_ok_i)
            st_d.sts = `DCSW_STS_RESET_VAL;                         // [RULE21]
    end

    // ------------------------------------------------------------------
    // register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            st_q       <= '0;
            st_q.cmd   <= `DCSW_CMD_RESET_VAL; // all stop bits active
        end
        else
            st_q <= st_d;
    end

    // ------------------------------------------------------------------
    // outputs, straight from flip-flops
    // ------------------------------------------------------------------
    assign dc_brake_o      = st_q.brake;
    assign coast_o         = st_q.coast;
    assign quick_stop_o    = st_q.qstop;
    assign freeze_o        = st_q.freeze;
    assign run_o           = st_q.run;
    assign jog_o           = st_q.cmd[`DCSW_CMD_JOG];         // [RULE7]
    assign ramp2_o         = st_q.cmd[`DCSW_CMD_RAMP2];       // [RULE8]
    assign reverse_o       = st_q.reverse;
    assign preset_sel_o    = st_q.cmd[`DCSW_CMD_PRESET_MSB:`DCSW_CMD_PRESET_LSB]; // [RULE23]
    assign setup_sel_o     = st_q.setup;
    assign relay1_o        = st_q.relay1;
    assign relay2_o        = st_q.relay2;
    assign trip_reset_o    = rst_pulse;
    assign speed_ref_o     = st_q.spd_ref;
    assign drive_condition_word_o          = st_q.sts;
    assign actual_output_frequency_value_o = st_q.freq_back;
endmodule : dcsw_word_ctrl
`default_nettype wire

// [dcsw_defs.svh]
// constants for the drive command/condition word block
`ifndef DCSW_DEFS_SVH
`define DCSW_DEFS_SVH
// command word bit positions
`define DCSW_CMD_PRESET_LSB   0
`define DCSW_CMD_PRESET_MSB   1
`define DCSW_CMD_RAMP_NBRAKE  2
`define DCSW_CMD_NCOAST       3
`define DCSW_CMD_NQSTOP       4
`define DCSW_CMD_NFREEZE      5
`define DCSW_CMD_START        6
`define DCSW_CMD_RESET        7
`define DCSW_CMD_JOG          8
`define DCSW_CMD_RAMP2        9
`define DCSW_CMD_VALID        10
`define DCSW_CMD_RELAY1       11
`define DCSW_CMD_RELAY2       12
`define DCSW_CMD_SETUP_LSB    13
`define DCSW_CMD_SETUP_MSB    14
`define DCSW_CMD_REVERSE      15
// condition word bit positions
`define DCSW_STS_CTRL_RDY     0
`define DCSW_STS_DRV_RDY      1
`define DCSW_STS_ENABLE       2
`define DCSW_STS_TRIP         3
`define DCSW_STS_ERROR        4
`define DCSW_STS_TRIPLOCK     6
`define DCSW_STS_WARNING      7
`define DCSW_STS_AT_SPEED     8
`define DCSW_STS_BUS_CTRL     9
`define DCSW_STS_FREQ_OK      10
`define DCSW_STS_IN_OP        11
`define DCSW_STS_AUTO_STOP    12
`define DCSW_STS_VOLT_EXC     13
`define DCSW_STS_TORQ_EXC     14
`define DCSW_STS_TIMER_EXC    15
// reset values
`define DCSW_CMD_RESET_VAL    16'h0000
`define DCSW_STS_RESET_VAL    16'h0000
// relative scaling: 100 % of reference
`define DCSW_REF_FULL_SCALE   16'h4000
`endif

// [dcsw_pkg.sv]
// types for the drive command/condition word block
package dcsw_pkg;
    // stop action chosen from the command word
    typedef enum logic [2:0] {
        DCSW_STOP_NONE,
        DCSW_STOP_COAST,
        DCSW_STOP_BRAKE,
        DCSW_STOP_QUICK,
        DCSW_STOP_RAMP
    } dcsw_stop_t;
endpackage : dcsw_pkg

// [dcsw_edge_det.sv]
// rising edge detector for the fault reset request
`timescale 1ns/1ps
`default_nettype none
module dcsw_edge_det
(
    // clock and reset
    input  wire logic clk_sys_i,
    input  wire logic reset_i,
    // sampled level and its qualifier
    input  wire logic level_i,
    input  wire logic sample_i,
    // one-cycle pulse on a 0-to-1 change
    output var  logic rise_o
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic last;   // level seen at the last sample
        logic rise;   // pulse register
    } dcsw_edge_st_t;

    dcsw_edge_st_t st_q;
    dcsw_edge_st_t st_d;

    // next state: only accepted samples move the history
    always_comb
    begin
        st_d      = st_q;
        st_d.rise = 1'b0;
        if (sample_i)
        begin
            st_d.rise = level_i & ~st_q.last; // [RULE6]
            st_d.last = level_i;
        end
    end

    // register
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            st_q <= '0;
        else
            st_q <= st_d;
    end

    assign rise_o = st_q.rise;
endmodule : dcsw_edge_det
`default_nettype wire

// [dcsw_word_ctrl_props.sv]
// assertion checker for the command and condition word block
`timescale 1ns/1ps
`default_nettype none
module dcsw_word_ctrl_props
#(
    parameter int WORD_W = 16
)
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_i,
    // watched inputs
    input  wire logic              cmd_strobe_i,
    input  wire logic [WORD_W-1:0] drive_command_word_i,
    input  wire logic [WORD_W-1:0] speed_ref_i,
    input  wire logic              link_ok_i,
    input  wire logic              ctrl_ready_i,
    input  wire logic              trip_i,
    input  wire logic              local_mode_i,
    input  wire logic              warning_i,
    input  wire logic              timer_exc_i,
    // watched outputs
    input  wire logic              coast_o,
    input  wire logic              dc_brake_o,
    input  wire logic              jog_o,
    input  wire logic              ramp2_o,
    input  wire logic [1:0]        preset_sel_o,
    input  wire logic              trip_reset_o,
    input  wire logic [WORD_W-1:0] speed_ref_o,
    input  wire logic [WORD_W-1:0] drive_condition_word_o
);
    logic acc;     // word taken at this edge
    logic rise;    // taken word raises the reset bit
    logic rdy;     // expected controls-ready flag
    logic prev7_q; // reset bit of the last taken word
    assign acc  = cmd_strobe_i & drive_command_word_i[10] & ~local_mode_i;
    assign rise = acc & drive_command_word_i[7] & ~prev7_q;
    assign rdy  = ctrl_ready_i & ~trip_i;
    // tracks the reset bit across taken words only
    always_ff @(posedge clk_sys_i)
        if (reset_i) prev7_q <= 1'b0;
        else if (acc) prev7_q <= drive_command_word_i[7];
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    coast_stop_a: assert property (acc && !drive_command_word_i[3] |-> ##2 coast_o)
        else $error("coast missing");
    dc_brake_a: assert property (acc && drive_command_word_i[3:2] == 2'b10 |-> ##2 dc_brake_o)
        else $error("brake missing");
    jog_ramp_a: assert property (acc |=> {ramp2_o, jog_o} == $past(drive_command_word_i[9:8]))
        else $error("jog or ramp wrong");
    preset_ref_a: assert property (acc |=> preset_sel_o == $past(drive_command_word_i[1:0])
        && speed_ref_o == $past(speed_ref_i)) else $error("preset or reference wrong");
    ignore_word_a: assert property (!acc |=> $stable(jog_o) && $stable(preset_sel_o))
        else $error("ignored word acted on");
    // the detector registers its pulse at the accepting edge itself
    reset_edge_a: assert property (rise |-> ##1 trip_reset_o ##1 !trip_reset_o)
        else $error("reset pulse wrong");
    pulse_cause_a: assert property (trip_reset_o |-> $past(rise))
        else $error("reset pulse without edge");
    link_lost_a: assert property (!link_ok_i |=> drive_condition_word_o == 16'h0000)
        else $error("word not cleared");
    ready_flag_a: assert property (link_ok_i |=> drive_condition_word_o[0] == $past(rdy))
        else $error("ready flag wrong");
    warn_flags_a: assert property (link_ok_i |=> drive_condition_word_o[15] == $past(timer_exc_i)
        && drive_condition_word_o[7] == $past(warning_i) && !drive_condition_word_o[5]) else $error("flags wrong");
    bus_ctrl_a: assert property (link_ok_i |=> drive_condition_word_o[9] == !$past(local_mode_i))
        else $error("bus flag wrong");
    taken_c: cover property (acc);
    pulse_c: cover property (trip_reset_o);
    lost_c: cover property (!link_ok_i);
endmodule : dcsw_word_ctrl_props
bind dcsw_word_ctrl dcsw_word_ctrl_props #(.WORD_W(WORD_W)) u_props (.*);
`default_nettype wire

// [dcsw_master_model.sv]
// behavioural bus master that hands telegram words to the block
`timescale 1ns/1ps
`default_nettype none
module dcsw_master_model
(
    // clock
    input  wire logic        clk_sys_i,
    // telegram words
    output var  logic        cmd_strobe_o,
    output var  logic [15:0] word_o,
    output var  logic [15:0] ref_o
);
    initial
    begin
        cmd_strobe_o = 1'b0;
        word_o       = 16'h0000;
        ref_o        = 16'h0000;
    end
    // one telegram for one edge, then inverted filler while idle
    task automatic send(input logic [15:0] w, input logic [15:0] r);
        @(posedge clk_sys_i);
        cmd_strobe_o <= 1'b1;
        word_o       <= w;
        ref_o        <= r;
        @(posedge clk_sys_i);
        cmd_strobe_o <= 1'b0;
        word_o       <= ~w;
        ref_o        <= ~r;
    endtask : send
endmodule : dcsw_master_model
`default_nettype wire

// [testbench.sv]
// self-checking bench for the command and condition word block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_sys_i = 1'b0, reset_i = 1'b1, cmd_strobe_i, link_ok_i = 1'b1, local_mode_i = 1'b0;
    logic ctrl_ready_i = 1'b1, drive_ready_i = 1'b1, start_sig_i = 1'b0;
    logic relay1_sel_cmd_i = 1'b0, relay2_sel_cmd_i = 1'b0, multi_setup_i = 1'b0, reverse_sel_bus_i = 1'b0;
    logic trip_i = 1'b0, error_i = 1'b0, triplock_i = 1'b0, warning_i = 1'b0, speed_lim_hit_i = 1'b0;
    logic overtemp_stop_i = 1'b0, volt_exc_i = 1'b0, torq_exc_i = 1'b0, timer_exc_i = 1'b0;
    logic [15:0] drive_command_word_i, speed_ref_i, actual_output_frequency_value_i = 16'h0000;
    logic dc_brake_o, coast_o, quick_stop_o, freeze_o, run_o, jog_o, ramp2_o, reverse_o, relay1_o, relay2_o;
    logic trip_reset_o;
    logic [1:0] preset_sel_o, setup_sel_o;
    logic [15:0] speed_ref_o, drive_condition_word_o, actual_output_frequency_value_o;
    int failures = 0, n_compared = 0, pulses = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) if (trip_reset_o === 1'b1) pulses++;
    dcsw_master_model mst (.clk_sys_i, .cmd_strobe_o(cmd_strobe_i), .word_o(drive_command_word_i), .ref_o(speed_ref_i));
    dcsw_word_ctrl dut (.clk_sys_i, .reset_i, .cmd_strobe_i, .drive_command_word_i, .speed_ref_i, .relay1_sel_cmd_i,
        .relay2_sel_cmd_i, .multi_setup_i, .reverse_sel_bus_i, .link_ok_i, .ctrl_ready_i, .drive_ready_i, .trip_i,
        .error_i, .triplock_i, .warning_i, .local_mode_i, .speed_lim_hit_i, .overtemp_stop_i, .volt_exc_i,
        .torq_exc_i, .timer_exc_i, .start_sig_i, .actual_output_frequency_value_i, .dc_brake_o, .coast_o,
        .quick_stop_o, .freeze_o, .run_o, .jog_o, .ramp2_o, .reverse_o, .preset_sel_o, .setup_sel_o, .relay1_o,
        .relay2_o, .trip_reset_o, .speed_ref_o, .drive_condition_word_o, .actual_output_frequency_value_o);
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : tick
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic give_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    // each stop mode, then run, then freeze against quick stop
    task automatic t_stops();
        logic [15:0] w [7] = '{16'h0474, 16'h0478, 16'h045C, 16'h046C, 16'h043C, 16'h047C, 16'h044C};
        logic [3:0]  e [7] = '{4'h8, 4'h4, 4'h2, 4'h1, 4'h0, 4'h0, 4'h2};
        for (int i = 0; i < 7; i++)
        begin
            mst.send(w[i], 16'h2000);
            tick(2);
            chk("stop_mode", e[i], {coast_o, dc_brake_o, freeze_o, quick_stop_o});
            if (i == 4 || i == 5) chk("run", i == 5, run_o);
        end
    endtask : t_stops
    // field decoding with configuration selects on and off
    task automatic t_fields();
        logic [15:0] w;
        logic s;
        for (int i = 0; i < 4; i++)
        begin
            s = (i < 2);
            w = 16'h047C | 16'(i) | 16'(i << 13) | (i[0] ? 16'h8900 : 16'h1200);
            @(posedge clk_sys_i);
            {relay1_sel_cmd_i, relay2_sel_cmd_i, multi_setup_i, reverse_sel_bus_i} <= {4{s}};
            mst.send(w, i[0] ? 16'hC000 : 16'h4000);
            tick(1);
            chk("preset_jog_ramp", {i[1:0], i[0], ~i[0]}, {preset_sel_o, jog_o, ramp2_o});
            chk("speed_ref", i[0] ? 16'hC000 : 16'h4000, speed_ref_o);
            tick(1);
            chk("relay_setup_rev", {s ? i[1:0] : 2'b00, i[0] & s, ~i[0] & s, i[0] & s},
                {setup_sel_o, relay1_o, relay2_o, reverse_o});
        end
    endtask : t_fields
    // invalid word and local mode are both ignored
    task automatic t_refuse();
        mst.send(16'h0074, 16'h0000);
        tick(2);
        chk("invalid_word", 3'b011, {coast_o, jog_o, speed_ref_o === 16'hC000});
        local_mode_i <= 1'b1;
        mst.send(16'h0474, 16'h0000);
        tick(2);
        chk("local_refused", 2'b00, {coast_o, drive_condition_word_o[9]});
        @(posedge clk_sys_i);
        local_mode_i <= 1'b0;
    endtask : t_refuse
    // trip reset fires only on a rise across taken words
    task automatic t_trip_reset();
        logic [15:0] w [6] = '{16'h04FC, 16'h04FC, 16'h007C, 16'h04FC, 16'h047C, 16'h04FC};
        pulses = 0;
        foreach (w[i]) mst.send(w[i], 16'h2000);
        tick(3);
        chk("reset_pulses", 16'd2, 16'(pulses));
    endtask : t_trip_reset
    // condition word in quiet and faulty states, then link loss
    task automatic t_status();
        @(posedge clk_sys_i);
        actual_output_frequency_value_i <= 16'h2000;
        tick(3);
        chk("status_quiet", 16'h0F07, drive_condition_word_o);
        chk("freq_back", 16'h2000, actual_output_frequency_value_o);
        {trip_i, triplock_i, error_i, warning_i, speed_lim_hit_i, overtemp_stop_i} <= '1;
        {volt_exc_i, torq_exc_i, timer_exc_i} <= '1;
        actual_output_frequency_value_i <= 16'h2001;
        tick(3);
        chk("status_faulty", 16'hFADE, drive_condition_word_o);
        link_ok_i <= 1'b0;
        tick(1);
        chk("status_lost", 16'h0000, drive_condition_word_o);
    endtask : t_status
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        t_stops();
        t_fields();
        t_refuse();
        t_trip_reset();
        t_status();
        give_verdict();
    end
    initial
    begin
        repeat (2000) @(posedge clk_sys_i);
        failures++;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
